// *** hdl/ucmd_rxcmd_gen.sv ***
// Purpose: phy-side generator of the ulpi receive command status byte
// Assumes: comparator and line pins are asynchronous, receiver on ulpi clock
// Notes:   only synchronous mode traffic; other modes just hold dir high
`timescale 1ns/10ps
module ucmd_rxcmd_gen
    import ucmd_pkg::*;
#(
    parameter int unsigned ALT_SRC_W = 8
) (
    // clocks and reset
    input  wire logic                 core_clk_i,
    input  wire logic                 ulpi_clk_i,
    input  wire logic                 arst_n_i,
    // asynchronous status pins
    input  wire logic                 dp_se_i,
    input  wire logic                 dm_se_i,
    input  wire logic                 sess_end_i,
    input  wire logic                 sess_vld_i,
    input  wire logic                 vbus_vld_i,
    input  wire logic                 id_pin_i,
    // core side control
    input  wire logic                 sync_mode_i,
    input  wire logic [ALT_SRC_W-1:0] alt_latch_i,
    input  wire logic [ALT_SRC_W-1:0] alt_mask_en_i,
    // receiver on the ulpi clock
    input  wire logic                 rx_active_i,
    input  wire logic                 rx_valid_i,
    input  wire logic [7:0]           rx_byte_i,
    input  wire logic                 rx_error_i,
    input  wire logic                 host_disc_i,
    // ulpi bus
    input  wire logic                 stp_i,
    input  wire logic [7:0]           data_i,
    output logic                      dir_o,
    output logic                      nxt_o,
    output logic [7:0]                data_o,
    output logic                      data_oe_o
);

    if (ALT_SRC_W < 1 || ALT_SRC_W > 32) begin : g_bad_w
        $error("ALT_SRC_W must lie in 1..32");
    end

    ////////////////////////////////////////////////////////////////////////
    // encoders

    // comparator outputs to a level code; sess_end high means below it
    function automatic logic [1:0] enc_vbus(input logic s_end,
                                            input logic s_vld,
                                            input logic v_vld);
        logic [1:0] code;
        code = VBUS_LOW;
        if (v_vld) begin
            code = VBUS_VVLD;
        end else if (s_vld) begin
            code = VBUS_SVLD;
        end else if (!s_end) begin
            code = VBUS_SESS;
        end
        return code;
    endfunction

    // disconnect wins over the receive flags
    function automatic logic [1:0] enc_rxe(input logic act,
                                           input logic err,
                                           input logic disc);
        logic [1:0] code;
        code = RXE_NONE;
        if (disc) begin
            code = RXE_DISC;
        end else if (act && err) begin
            code = RXE_ERROR;
        end else if (act) begin
            code = RXE_ACTIVE;
        end
        return code;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reset release, one synchroniser per domain

    logic [1:0] core_rst_ff;
    logic [1:0] link_rst_ff;
    logic       core_rst_n;
    logic       link_rst_n;

    // asynchronous assert, release through two flops
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            core_rst_ff <= 2'h0;
        end else begin
            core_rst_ff <= {core_rst_ff[0], 1'b1};
        end
    end

    // same on the ulpi clock
    always_ff @(posedge ulpi_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            link_rst_ff <= 2'h0;
        end else begin
            link_rst_ff <= {link_rst_ff[0], 1'b1};
        end
    end

    assign core_rst_n = core_rst_ff[1];
    assign link_rst_n = link_rst_ff[1];

    ////////////////////////////////////////////////////////////////////////
    // core domain: pin synchronisers and the status word

    logic [5:0] pin_s1_ff;
    logic [5:0] pin_s2_ff;
    logic [7:0] word_ff;

    // pins pass two flops; stage one feeds stage two only
    always_ff @(posedge core_clk_i or negedge core_rst_n) begin
        if (!core_rst_n) begin
            pin_s1_ff <= 6'h00;
            pin_s2_ff <= 6'h00;
        end else begin
            pin_s1_ff <= {id_pin_i, vbus_vld_i, sess_vld_i, sess_end_i,
                          dm_se_i, dp_se_i};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // assemble the pin and interrupt fields; rx field is filled on the link
    always_ff @(posedge core_clk_i or negedge core_rst_n) begin
        if (!core_rst_n) begin
            word_ff <= STATUS_RST;
        end else begin
            word_ff[LS_LO]            <= pin_s2_ff[0];
            word_ff[LS_LO+1]          <= pin_s2_ff[1];
            word_ff[VBUS_LO +: 2]     <= enc_vbus(pin_s2_ff[2],
                                                  pin_s2_ff[3],
                                                  pin_s2_ff[4]);
            word_ff[RXE_LO +: 2]      <= RXE_NONE;
            word_ff[ID_BIT]           <= pin_s2_ff[5];
            word_ff[ALT_BIT]          <= |(alt_latch_i & alt_mask_en_i);
        end
    end

    // word crosses by handshake so all bits arrive together
    ucmd_xfer_if #(.W(8)) xfer_bus ();

    assign xfer_bus.src_word = word_ff;

    ucmd_word_xfer #(
        .W (8)
    ) u_xfer (
        .core_clk_i   (core_clk_i),
        .core_rst_n_i (core_rst_n),
        .link_clk_i   (ulpi_clk_i),
        .link_rst_n_i (link_rst_n),
        .bus          (xfer_bus.xfer)
    );

    ////////////////////////////////////////////////////////////////////////
    // link domain: mode level and current byte

    logic [1:0]  mode_sync_ff;
    logic        sync_mode;
    logic [7:0]  cur_byte;

    // mode is a slow level, two flops suffice
    always_ff @(posedge ulpi_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            mode_sync_ff <= 2'h0;
        end else begin
            mode_sync_ff <= {mode_sync_ff[0], sync_mode_i};
        end
    end

    assign sync_mode = mode_sync_ff[1];

    // rx field taken live so every byte is current when driven
    always_comb begin
        cur_byte              = xfer_bus.dst_word;
        cur_byte[RXE_LO +: 2] = enc_rxe(rx_active_i, rx_error_i,
                                        host_disc_i);
    end

    ////////////////////////////////////////////////////////////////////////
    // link domain: event bookkeeping

    ucmd_state_e state_ff;
    ucmd_state_e nxt_state;
    logic [7:0]  sent_ff;
    logic        pend_ff;
    logic        announce_ff;
    logic        stp_seen_ff;
    logic        evt_pend;
    logic        send_now;
    logic        set_pend;
    logic        nxt_dir;
    logic        nxt_nxt;
    logic        nxt_oe;
    logic [7:0]  nxt_data;

    // any difference from the last reported byte is an event
    assign evt_pend = pend_ff || (cur_byte != sent_ff);

    // remember what the link last saw
    always_ff @(posedge ulpi_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sent_ff <= STATUS_RST;
        end else if (send_now) begin
            sent_ff <= cur_byte;
        end
    end

    // forced report; a new set in the clearing cycle wins
    always_ff @(posedge ulpi_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            pend_ff <= 1'b0;
        end else if (set_pend) begin
            pend_ff <= 1'b1;
        end else if (send_now) begin
            pend_ff <= 1'b0;
        end
    end

    // armed whenever dir is released after start-up or a foreign mode
    always_ff @(posedge ulpi_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            announce_ff <= 1'b0;
        end else if (state_ff == UCMD_HOLD && sync_mode) begin
            announce_ff <= 1'b1;
        end else if (set_pend) begin
            announce_ff <= 1'b0;
        end
    end

    // transmit ends on stp high followed by stp low
    always_ff @(posedge ulpi_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            stp_seen_ff <= 1'b0;
        end else if (state_ff != UCMD_TX) begin
            stp_seen_ff <= 1'b0;
        end else if (stp_i) begin
            stp_seen_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link domain: bus ownership sequencer

    // outputs are the values for the next cycle, registered below
    always_comb begin
        nxt_state = state_ff;
        nxt_dir   = 1'b0;
        nxt_nxt   = 1'b0;
        nxt_oe    = 1'b0;
        nxt_data  = BUS_IDLE;
        send_now  = 1'b0;
        set_pend  = 1'b0;
        case (state_ff)
            UCMD_HOLD: begin
                // start-up or foreign mode: phy keeps dir, bus not ours
                nxt_dir = 1'b1;
                if (sync_mode) begin
                    nxt_state = UCMD_TA_DN;
                    nxt_dir   = 1'b0;
                end
            end
            UCMD_TA_DN: begin
                // turnaround after dir fell; bus value ignored
                nxt_state = UCMD_IDLE;
            end
            UCMD_IDLE: begin
                if (!sync_mode) begin
                    nxt_state = UCMD_HOLD;
                    nxt_dir   = 1'b1;
                end else if (rx_active_i) begin
                    nxt_state = UCMD_TA_UP;
                    nxt_dir   = 1'b1;
                    nxt_nxt   = 1'b1;
                end else if (data_i[7:6] == CMD_TRANSMIT) begin
                    nxt_state = UCMD_TX;
                end else if (announce_ff && !stp_i) begin
                    set_pend  = 1'b1;
                end else if (evt_pend && !stp_i &&
                             data_i == BUS_IDLE) begin
                    nxt_state = UCMD_TA_UP;
                    nxt_dir   = 1'b1;
                end
            end
            UCMD_TA_UP: begin
                // turnaround after dir rose, then drive
                nxt_dir = 1'b1;
                if (rx_active_i) begin
                    nxt_state = UCMD_RX;
                    nxt_oe    = 1'b1;
                    nxt_nxt   = rx_valid_i;
                    nxt_data  = rx_valid_i ? rx_byte_i : cur_byte;
                    send_now  = !rx_valid_i;
                end else begin
                    nxt_state = UCMD_SEND;
                    nxt_oe    = 1'b1;
                    nxt_data  = cur_byte;
                    send_now  = 1'b1;
                end
            end
            UCMD_SEND: begin
                // lone byte done; a new packet may follow at once
                if (rx_active_i) begin
                    nxt_state = UCMD_RX;
                    nxt_dir   = 1'b1;
                    nxt_oe    = 1'b1;
                    nxt_nxt   = rx_valid_i;
                    nxt_data  = rx_valid_i ? rx_byte_i : cur_byte;
                    send_now  = !rx_valid_i;
                end else begin
                    nxt_state = UCMD_TA_DN;
                end
            end
            UCMD_RX: begin
                nxt_dir = 1'b1;
                nxt_oe  = 1'b1;
                if (rx_active_i) begin
                    nxt_nxt  = rx_valid_i;
                    nxt_data = rx_valid_i ? rx_byte_i : cur_byte;
                    send_now = !rx_valid_i;
                end else begin
                    // closing byte reports receive no longer active
                    nxt_state = UCMD_SEND;
                    nxt_data  = cur_byte;
                    send_now  = 1'b1;
                end
            end
            UCMD_TX: begin
                // events wait; link owns the bus until stp falls
                if (!sync_mode) begin
                    nxt_state = UCMD_HOLD;
                    nxt_dir   = 1'b1;
                end else if (stp_seen_ff && !stp_i) begin
                    nxt_state = UCMD_IDLE;
                end
            end
            default: begin
                nxt_state = UCMD_HOLD;
                nxt_dir   = 1'b1;
            end
        endcase
    end

    // state and pins change together so outputs come from flops
    always_ff @(posedge ulpi_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            state_ff  <= UCMD_HOLD;
            dir_o     <= 1'b1;   // phy holds the bus through start-up
            nxt_o     <= 1'b0;
            data_o    <= BUS_IDLE;
            data_oe_o <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            dir_o     <= nxt_dir;
            nxt_o     <= nxt_nxt;
            data_o    <= nxt_data;
            data_oe_o <= nxt_oe;
        end
    end

endmodule

// *** hdl/ucmd_word_xfer.sv ***
// Purpose: toggle handshake moving a word from core clock to link clock
// Assumes: both resets are released by their own synchronisers
// Notes:   a new word is offered only after the previous one was taken
`timescale 1ns/10ps
module ucmd_word_xfer
    import ucmd_pkg::*;
#(
    parameter int unsigned W = 8
) (
    // core side
    input  wire logic core_clk_i,
    input  wire logic core_rst_n_i,
    // link side
    input  wire logic link_clk_i,
    input  wire logic link_rst_n_i,
    // carried words
    ucmd_xfer_if.xfer bus
);
    logic [W-1:0] hold_ff;
    logic         req_ff;
    logic [1:0]   ack_sync_ff;
    logic [2:0]   req_sync_ff;
    logic         ack_ff;
    logic [W-1:0] word_ff;
    logic         new_ff;

    ////////////////////////////////////////////////////////////////////////
    // source: capture and toggle the request once the last one is acked
    always_ff @(posedge core_clk_i or negedge core_rst_n_i) begin
        if (!core_rst_n_i) begin
            hold_ff <= '0;
            req_ff  <= 1'b0;
        end else if (req_ff == ack_sync_ff[1]) begin
            hold_ff <= bus.src_word;
            req_ff  <= ~req_ff;
        end
    end

    // ack back into the core domain
    always_ff @(posedge core_clk_i or negedge core_rst_n_i) begin
        if (!core_rst_n_i) begin
            ack_sync_ff <= '0;
        end else begin
            ack_sync_ff <= {ack_sync_ff[0], ack_ff};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // destination: stage 0 feeds stage 1 only, edge seen on stages 1 and 2
    always_ff @(posedge link_clk_i or negedge link_rst_n_i) begin
        if (!link_rst_n_i) begin
            req_sync_ff <= '0;
            ack_ff      <= 1'b0;
            word_ff     <= '0;
            new_ff      <= 1'b0;
        end else begin
            req_sync_ff <= {req_sync_ff[1:0], req_ff};
            new_ff      <= req_sync_ff[2] ^ req_sync_ff[1];
            if (req_sync_ff[2] ^ req_sync_ff[1]) begin
                word_ff <= hold_ff;   // hold_ff stable while req pending
                ack_ff  <= req_sync_ff[1];
            end
        end
    end

    assign bus.dst_word = word_ff;
    assign bus.dst_new  = new_ff;
endmodule

// *** include/ucmd_pkg.sv ***
// Purpose: shared constants and types of the receive command generator
// Assumes: ulpi synchronous mode clock on the link side, core clock elsewhere
// Notes:   field positions, encodings and reset values live only here
//
// Overview of operation
// - status byte sent only in synchronous mode while the phy owns the bus
// - any change of the dp/dm line state triggers a status byte
// - any change of the encoded vbus level or of the id pin triggers a status byte
// - during a receive, every dir-high nxt-low cycle carries a status byte
// - after start-up dir release with stp low, current status is sent
// - leaving a non-synchronous mode, status is sent once stp low, dir low
// - events during a transmit wait until stp rises and falls again
// - the byte holds status sampled when sent, not when the event occurred
// - bits 1:0 are line state, bit 0 follows dp, bit 1 follows dm
// - bits 3:2 encode vbus level against the three comparator thresholds
// - bits 5:4 encode idle, rx active, host disconnect, rx error
// - bit 6 mirrors the id pin, low for an a-device
// - bit 7 flags any unmasked latched non-usb interrupt source
// - one idle turnaround cycle each time dir changes, bus value ignored
package ucmd_pkg;

    // byte field positions
    localparam int unsigned LS_LO    = 0;
    localparam int unsigned VBUS_LO  = 2;
    localparam int unsigned RXE_LO   = 4;
    localparam int unsigned ID_BIT   = 6;
    localparam int unsigned ALT_BIT  = 7;

    // encoded vbus levels
    localparam logic [1:0] VBUS_LOW   = 2'h0;
    localparam logic [1:0] VBUS_SESS  = 2'h1;
    localparam logic [1:0] VBUS_SVLD  = 2'h2;
    localparam logic [1:0] VBUS_VVLD  = 2'h3;

    // encoded receive events
    localparam logic [1:0] RXE_NONE   = 2'h0;
    localparam logic [1:0] RXE_ACTIVE = 2'h1;
    localparam logic [1:0] RXE_DISC   = 2'h2;
    localparam logic [1:0] RXE_ERROR  = 2'h3;

    // link command byte details
    localparam logic [1:0] CMD_TRANSMIT = 2'h1;
    localparam logic [7:0] BUS_IDLE     = 8'h00;

    // reset values
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam int unsigned SYNC_STAGES = 2;

    // link side states, gray along idle, up, send, down
    typedef enum logic [2:0] {
        UCMD_IDLE  = 3'h0,
        UCMD_TA_UP = 3'h1,
        UCMD_SEND  = 3'h3,
        UCMD_TA_DN = 3'h2,
        UCMD_RX    = 3'h6,
        UCMD_TX    = 3'h7,
        UCMD_HOLD  = 3'h4
    } ucmd_state_e;

endpackage

// *** include/ucmd_xfer_if.sv ***
// Purpose: carries the status word between the two clock domains
// Assumes: src_word is stable in the core domain, dst side on link clock
// Notes:   dst_new pulses one link cycle when dst_word takes a new copy
`timescale 1ns/10ps
interface ucmd_xfer_if #(
    parameter int unsigned W = 8
);
    logic [W-1:0] src_word;
    logic [W-1:0] dst_word;
    logic         dst_new;

    modport user (output src_word, input dst_word, input dst_new);
    modport xfer (input src_word, output dst_word, output dst_new);
endinterface

// *** verification/ucmd_link_model.sv ***
// Purpose: link controller model on the ulpi bus
// Assumes: the phy byte is on bus_i whenever drv_i is high
// Notes:   no register traffic
`timescale 1ns/10ps
module ucmd_link_model (
    // ulpi bus
    input  wire logic        ulpi_clk_i,
    input  wire logic        dir_i,
    input  wire logic        nxt_i,
    input  wire logic        drv_i,
    input  wire logic [7:0]  bus_i,
    output logic             stp_o,
    output logic [7:0]       link_d_o,
    output logic             link_oe_o,
    // captured status bytes
    output logic [7:0]       last_cmd_o,
    output logic [15:0]      n_cmd_o
);
    logic dir_q;
    // idle bus; dir counts as high until seen low
    initial begin
        {stp_o, link_d_o, last_cmd_o, n_cmd_o, dir_q} = 34'h1;
    end
    ////////////////////////////////////////////////////////////
    // release as dir rises, drive one cycle after it falls
    assign link_oe_o = !dir_i && !dir_q;
    // log status bytes: phy owns bus past turnaround, nxt low
    always @(posedge ulpi_clk_i) begin
        dir_q <= dir_i;
        if (dir_i && dir_q && !nxt_i && drv_i) begin
            last_cmd_o <= bus_i;
            n_cmd_o <= n_cmd_o + 16'h1;
        end
    end
    // transmit command, then one stp cycle at idle
    task automatic send_tx(input int len);
        repeat (4) @(posedge ulpi_clk_i);
        link_d_o <= 8'h41;
        repeat (len) @(posedge ulpi_clk_i);
        stp_o <= 1'b1;
        link_d_o <= 8'h00;
        @(posedge ulpi_clk_i);
        stp_o <= 1'b0;
    endtask
endmodule

// *** verification/ucmd_rxcmd_gen_checker.sv ***
// Purpose: bus timing checks for the status byte generator
// Assumes: every watched signal is sampled on the ulpi clock
// Notes:   byte contents are judged in the bench
`timescale 1ns/10ps
module ucmd_rxcmd_gen_checker
    import ucmd_pkg::*;
(
    // clock and reset
    input wire logic       ulpi_clk_i,
    input wire logic       arst_n_i,
    // ulpi bus
    input wire logic       stp_i,
    input wire logic [7:0] data_i,
    input wire logic       dir_o,
    input wire logic       nxt_o,
    input wire logic       data_oe_o
);
    logic tx_ff;
    logic tx_cmd;
    default clocking cb @(posedge ulpi_clk_i); endclocking
    default disable iff (!arst_n_i);
    ////////////////////////////////////////////////////////////
    // a transmit is open from its command until stp
    assign tx_cmd = data_i[7:6] == CMD_TRANSMIT;
    always_ff @(posedge ulpi_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_ff <= 1'b0;
        end else if (stp_i) begin
            tx_ff <= 1'b0;
        end else if (!dir_o && !$past(dir_o) && tx_cmd) begin
            tx_ff <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////
    property p_oe_dir; data_oe_o |-> dir_o; endproperty
    a_oe_dir: assert property (p_oe_dir)
        else $error("bus driven without dir");
    property p_turn; dir_o != $past(dir_o) |-> !data_oe_o; endproperty
    a_turn: assert property (p_turn)
        else $error("bus driven in turnaround");
    property p_gap; $fell(dir_o) |-> !dir_o [*2]; endproperty
    a_gap: assert property (p_gap)
        else $error("dir back up without turnaround");
    property p_lone; $rose(dir_o) && !nxt_o ##1 data_oe_o |=> !dir_o; endproperty
    a_lone: assert property (p_lone)
        else $error("dir held after lone status byte");
    property p_rx_up; $rose(dir_o) && nxt_o |=> data_oe_o; endproperty
    a_rx_up: assert property (p_rx_up)
        else $error("receive start without byte");
    property p_own; dir_o && $past(data_oe_o) |-> data_oe_o; endproperty
    a_own: assert property (p_own)
        else $error("owned bus left undriven");
    property p_stp; stp_i && !dir_o |=> !dir_o; endproperty
    a_stp: assert property (p_stp)
        else $error("dir raised while stp high");
    property p_tx; tx_ff |=> !dir_o; endproperty
    a_tx: assert property (p_tx)
        else $error("status byte during transmit");
endmodule

bind ucmd_rxcmd_gen ucmd_rxcmd_gen_checker i_chk (
    .ulpi_clk_i(ulpi_clk_i), .arst_n_i(arst_n_i), .stp_i(stp_i),
    .data_i(data_i), .dir_o(dir_o), .nxt_o(nxt_o), .data_oe_o(data_oe_o));

// *** verification/ucmd_rxcmd_gen_tb.sv ***
// Purpose: self-checking bench for the status byte generator
// Assumes: link model on the bus, pins steady between status bytes
// Notes:   expected bytes come from the pins driven
`timescale 1ns/10ps
module ucmd_rxcmd_gen_tb
    import ucmd_pkg::*;
;
    logic core_clk, ulpi_clk, arst_n, dp, dm, s_end, s_vld, v_vld, id;
    logic sync_mode, rx_active, rx_valid, rx_err, host_disc, stp, got;
    logic dir, nxt, data_oe, link_oe;
    logic [7:0] alt_latch, alt_mask, rx_byte, data_o, link_d, bus, last_bus;
    logic [7:0] last_cmd;
    logic [15:0] n_cmd, n0, nb, seen;
    int n_mismatch, tests_run;

    ucmd_rxcmd_gen #(.ALT_SRC_W(8)) i_dut (
        .core_clk_i(core_clk), .ulpi_clk_i(ulpi_clk), .arst_n_i(arst_n),
        .dp_se_i(dp), .dm_se_i(dm), .sess_end_i(s_end), .sess_vld_i(s_vld),
        .vbus_vld_i(v_vld), .id_pin_i(id), .sync_mode_i(sync_mode),
        .alt_latch_i(alt_latch), .alt_mask_en_i(alt_mask),
        .rx_active_i(rx_active), .rx_valid_i(rx_valid), .rx_byte_i(rx_byte),
        .rx_error_i(rx_err), .host_disc_i(host_disc), .stp_i(stp),
        .data_i(bus), .dir_o(dir), .nxt_o(nxt), .data_o(data_o),
        .data_oe_o(data_oe));
    ucmd_link_model i_link (.ulpi_clk_i(ulpi_clk), .dir_i(dir), .nxt_i(nxt),
        .drv_i(data_oe), .bus_i(bus), .stp_o(stp), .link_d_o(link_d),
        .link_oe_o(link_oe), .last_cmd_o(last_cmd), .n_cmd_o(n_cmd));
    ////////////////////////////////////////////////////////////
    // clocks with unrelated phase
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        ulpi_clk = 1'b0;
        #5;
        forever #16 ulpi_clk = ~ulpi_clk;
    end
    // undriven bus shows the inverse of its last value
    assign bus = data_oe ? data_o : (link_oe ? link_d : ~last_bus);
    always @(posedge ulpi_clk) last_bus <= bus;

    task automatic check(input string what, input logic [15:0] s,
                         input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask
    function automatic logic [7:0] exp_byte();
        logic [1:0] vb;
        logic [1:0] rx;
        vb = s_end ? VBUS_LOW : VBUS_SESS;
        vb = v_vld ? VBUS_VVLD : (s_vld ? VBUS_SVLD : vb);
        rx = rx_active ? (rx_err ? RXE_ERROR : RXE_ACTIVE) : RXE_NONE;
        rx = host_disc ? RXE_DISC : rx;
        return {|(alt_latch & alt_mask), id, rx, vb, dm, dp};
    endfunction
    function automatic logic [15:0] want();
        return {8'h1, exp_byte()};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge ulpi_clk);
    endtask
    // bounded wait for the next status byte the link logs
    task automatic wcmd();
        n0 = n_cmd;
        got = 1'b0;
        for (int i = 0; i < 60 && !got; i++) begin
            @(posedge ulpi_clk);
            #1;
            got = n_cmd != n0;
        end
        seen = 16'({got, last_cmd});
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_pins();
        logic [5:0] pv [10];
        pv = '{6'h2e, 6'h2f, 6'h2c, 6'h2d, 6'h31, 6'h21, 6'h39, 6'h3d,
               6'h1d, 6'h3d};
        for (int i = 0; i < 10; i++) begin
            @(posedge core_clk);
            {id, s_end, s_vld, v_vld, dm, dp} <= pv[i];
            wcmd();
            if (i < 4) check("line", seen, want());
            else check("vbus id", seen, want());
        end
    endtask
    task automatic t_alt();
        @(posedge core_clk);
        alt_latch <= 8'h05;
        wcmd();
        check("masked", 16'(got), 16'h0);
        @(posedge core_clk);
        alt_mask <= 8'h04;
        wcmd();
        check("alt set", seen, want());
        @(posedge core_clk);
        alt_latch <= 8'h00;
        wcmd();
        check("alt clear", seen, want());
    endtask
    // two pin changes in a transmit; one byte after stp
    task automatic t_tx();
        nb = n_cmd;
        fork
            i_link.send_tx(20);
            begin
                repeat (40) @(posedge core_clk);
                dp <= ~dp;
                repeat (30) @(posedge core_clk);
                dm <= ~dm;
            end
        join
        check("held", n_cmd, nb);
        wcmd();
        check("after tx", seen, want());
    endtask
    task automatic t_rx();
        tick(1);
        rx_active <= 1'b1;
        rx_byte <= 8'ha5;
        tick(8);
        #1;
        nb = n_cmd;
        tick(4);
        #1;
        check("rx count", n_cmd, nb + 16'h4);
        check("rx act", 16'(last_cmd), 16'(exp_byte()));
        tick(1);
        rx_valid <= 1'b1;
        tick(1);
        rx_valid <= 1'b0;
        rx_err <= 1'b1;
        tick(6);
        #1;
        check("rx err", 16'(last_cmd), 16'(exp_byte()));
        tick(1);
        {rx_active, rx_err} <= 2'h0;
        tick(10);
        #1;
        check("rx end", 16'(last_cmd), 16'(exp_byte()));
        for (int i = 0; i < 2; i++) begin
            tick(1);
            host_disc <= ~host_disc;
            wcmd();
            check("disc", seen, want());
        end
    endtask
    // foreign mode events wait for sync mode
    task automatic t_mode();
        @(posedge core_clk);
        sync_mode <= 1'b0;
        tick(20);
        nb = n_cmd;
        @(posedge core_clk);
        dp <= ~dp;
        tick(20);
        check("quiet", n_cmd, nb);
        @(posedge core_clk);
        sync_mode <= 1'b1;
        wcmd();
        check("mode exit", seen, want());
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // hang guard, about twenty times the expected run
    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        {dp, dm, s_end, s_vld, v_vld, id, sync_mode} = 7'h4f;
        {rx_active, rx_valid, rx_err, host_disc, arst_n} = 5'h0;
        {rx_byte, alt_latch, alt_mask, last_bus} = 32'h0;
        n_mismatch = 0;
        tests_run = 0;
        // reset spans the slower clock so both domains see it
        tick(4);
        arst_n <= 1'b1;
        wcmd();
        check("startup", seen, want());
        t_pins();
        t_alt();
        t_tx();
        t_rx();
        t_mode();
        give_verdict();
    end
endmodule
